// ### asx_defines.svh
// Widths, field positions, reset values and timing counts for the
// ALU slice. Assumes it is included by bare name wherever needed.
`ifndef ASX_DEFINES_SVH
`define ASX_DEFINES_SVH

`define ASX_DATA_W      8
`define ASX_ADDR_W      7
`define ASX_NIB_HI_MSB  7
`define ASX_NIB_HI_LSB  4
`define ASX_NIB_LO_MSB  3
`define ASX_NIB_LO_LSB  0
`define ASX_DEST_ACC    1'b0
`define ASX_DEST_FILE   1'b1
`define ASX_ACC_RST     8'h00
`define ASX_DATA_RST    8'h00
`define ASX_ADDR_RST    7'h00
`define ASX_FLAG_RST    1'b0
`define ASX_LATENCY     1

`endif

// ### asx_pkg.sv
// Types shared by the ALU slice and its core.
// Assumes asx_defines.svh is on the include path.
`include "asx_defines.svh"

package asx_pkg;

    typedef logic [`ASX_DATA_W-1:0] asx_data_t;
    typedef logic [`ASX_ADDR_W-1:0] asx_addr_t;

    // Operation select from the instruction decoder
    typedef enum logic [1:0] {
        OP_SUB_W_FROM_FILE     = 2'h0,
        OP_SWAP_NIBBLES_FILE   = 2'h1,
        OP_XOR_LITERAL_INTO_ACC = 2'h2,
        OP_XOR_ACC_WITH_FILE   = 2'h3
    } asx_op_e;

    // Zero detect, used by the core and by the checks
    function automatic logic asx_is_zero(input asx_data_t value);
        asx_is_zero = (value == `ASX_DATA_RST);
    endfunction

endpackage

// ### asx_alu_if.sv
// Carrier between the ALU control module and its arithmetic core.
// Assumes both ends run in the same clock domain; no state inside.
`timescale 1ns/1ps

interface asx_alu_if;
    import asx_pkg::*;

    asx_op_e   op;
    logic      dest_bit;
    asx_data_t acc;
    asx_data_t file_val;
    asx_data_t literal;
    asx_data_t result;
    logic      carry;
    logic      digit_carry_flag;
    logic      zero;
    logic      upd_carry;
    logic      upd_zero;
    logic      to_file;

    modport core (
        input  op,
        input  dest_bit,
        input  acc,
        input  file_val,
        input  literal,
        output result,
        output carry,
        output digit_carry_flag,
        output zero,
        output upd_carry,
        output upd_zero,
        output to_file
    );

    modport ctl (
        output op,
        output dest_bit,
        output acc,
        output file_val,
        output literal,
        input  result,
        input  carry,
        input  digit_carry_flag,
        input  zero,
        input  upd_carry,
        input  upd_zero,
        input  to_file
    );
endinterface

// ### asx_alu_core.sv
// Combinational result and flag logic for the four operations.
// Assumes operands are stable for the cycle they are presented.
`timescale 1ns/1ps
`include "asx_defines.svh"

module asx_alu_core
    import asx_pkg::*;
(
    asx_alu_if.core bus
);

    logic [`ASX_DATA_W:0]       diff_full;
    logic [`ASX_NIB_LO_MSB+1:0] diff_low;

    // Subtract as f + ~w + 1 so the carry out means no borrow
    assign diff_full = {1'b0, bus.file_val} + {1'b0, ~bus.acc} + 9'h001; // RULE_01
    assign diff_low  = {1'b0, bus.file_val[`ASX_NIB_LO_MSB:0]}
                     + {1'b0, ~bus.acc[`ASX_NIB_LO_MSB:0]} + 5'h01;

    // Per-operation result, flag enables and destination
    always_comb begin
        bus.result           = `ASX_DATA_RST;
        bus.upd_carry        = 1'b0;
        bus.upd_zero         = 1'b0;
        bus.to_file          = (bus.dest_bit == `ASX_DEST_FILE); // RULE_02
        case (bus.op)
            OP_SUB_W_FROM_FILE: begin
                bus.result    = diff_full[`ASX_DATA_W-1:0]; // RULE_01
                bus.upd_carry = 1'b1;
                bus.upd_zero  = 1'b1;
            end
            OP_SWAP_NIBBLES_FILE: begin
                bus.result = {bus.file_val[`ASX_NIB_LO_MSB:`ASX_NIB_LO_LSB],
                              bus.file_val[`ASX_NIB_HI_MSB:`ASX_NIB_HI_LSB]}; // RULE_03
            end
            OP_XOR_LITERAL_INTO_ACC: begin
                bus.result   = bus.acc ^ bus.literal; // RULE_04
                bus.upd_zero = 1'b1;
                bus.to_file  = 1'b0; // Literal form has no destination bit
            end
            OP_XOR_ACC_WITH_FILE: begin
                bus.result   = bus.acc ^ bus.file_val; // RULE_05
                bus.upd_zero = 1'b1;
            end
            default: begin
                bus.result = `ASX_DATA_RST;
            end
        endcase
    end

    // Flag values; carries mean no borrow out of bit 7 and bit 3
    assign bus.carry            = diff_full[`ASX_DATA_W]; // RULE_06
    assign bus.digit_carry_flag = diff_low[`ASX_NIB_LO_MSB+1]; // RULE_06
    assign bus.zero             = asx_is_zero(bus.result); // RULE_06

endmodule

// ### asx_alu_top.sv
// ALU slice for subtract, nibble swap and the two exclusive-OR forms,
// holding the working register and its carry, digit carry and zero flags.
// Assumes decoder and register file share clk_sys; file read data is
// valid in the same cycle as op_valid.
`timescale 1ns/1ps
`include "asx_defines.svh"

// Functional notes
// RULE_01: Subtract working value from file value, set flags
// RULE_02: Destination bit zero to W, one to file
// RULE_03: Swap nibbles of file value, flags untouched
// RULE_04: Literal XOR into W, only zero flag
// RULE_05: File XOR with W, steered, only zero
// RULE_06: Zero on zero result; carries mean no borrow
module asx_alu_top
    import asx_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire logic      reset,
    input  wire logic      op_valid,
    input  wire asx_op_e   op_code,
    input  wire logic      dest_bit,
    input  wire asx_addr_t file_addr,
    input  wire asx_data_t file_rd_data,
    input  wire asx_data_t op_literal,
    output logic           done,
    output asx_data_t      acc,
    output logic           file_we,
    output asx_addr_t      file_wr_addr,
    output asx_data_t      file_wr_data,
    output logic           flag_carry,
    output logic           digit_carry_flag,
    output logic           flag_zero
);

    // Carrier to the arithmetic core; only this module feeds its operands
    asx_alu_if alu_bus ();

    logic      next_done;
    asx_data_t next_acc;
    logic      next_file_we;
    asx_addr_t next_file_wr_addr;
    asx_data_t next_file_wr_data;
    logic      next_flag_carry;
    logic      next_digit_carry_flag;
    logic      next_flag_zero;

    // Operands straight from decoder, register file and the W register
    assign alu_bus.op       = op_code;
    assign alu_bus.dest_bit = dest_bit;
    assign alu_bus.acc      = acc;
    assign alu_bus.file_val = file_rd_data;
    assign alu_bus.literal  = op_literal;

    asx_alu_core u_core (
        .bus (alu_bus)
    );

    // Next state: one result per accepted operation
    always_comb begin
        next_done             = op_valid;
        next_acc              = acc;
        next_file_we          = 1'b0;
        next_file_wr_addr     = file_wr_addr;
        next_file_wr_data     = file_wr_data;
        next_flag_carry       = flag_carry;
        next_digit_carry_flag = digit_carry_flag;
        next_flag_zero        = flag_zero;
        if (op_valid) begin
            // Every result goes out, W ones too, so the far side sees
            // each answer; only file_we commits it to the register file
            next_file_wr_data = alu_bus.result;
            if (alu_bus.to_file) begin
                next_file_we      = 1'b1; // RULE_02
                next_file_wr_addr = file_addr;
            end else begin
                next_acc = alu_bus.result; // RULE_02
            end
            // Flags held unless the operation owns them
            if (alu_bus.upd_carry) begin
                next_flag_carry       = alu_bus.carry; // RULE_01
                next_digit_carry_flag = alu_bus.digit_carry_flag; // RULE_01
            end
            if (alu_bus.upd_zero) begin
                next_flag_zero = alu_bus.zero; // RULE_06
            end
        end
    end

    // Registers; sync reset clears W, flags and the write strobe
    // Sync reset only, so no reset path can race the file write strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            done             <= 1'b0;
            acc              <= `ASX_ACC_RST;
            file_we          <= 1'b0;
            file_wr_addr     <= `ASX_ADDR_RST;
            file_wr_data     <= `ASX_DATA_RST;
            flag_carry       <= `ASX_FLAG_RST;
            digit_carry_flag <= `ASX_FLAG_RST;
            flag_zero        <= `ASX_FLAG_RST;
        end else begin
            done             <= next_done;
            acc              <= next_acc;
            file_we          <= next_file_we;
            file_wr_addr     <= next_file_wr_addr;
            file_wr_data     <= next_file_wr_data;
            flag_carry       <= next_flag_carry;
            digit_carry_flag <= next_digit_carry_flag;
            flag_zero        <= next_flag_zero;
        end
    end

    // Helper taps so the checks can look back at nibbles
    // Checks sample operands at issue and results one edge later
    logic [3:0] f_lo;
    logic [3:0] w_lo;
    assign f_lo = file_rd_data[3:0];
    assign w_lo = acc[3:0];

    sequence s_issue_sub;
        op_valid && (op_code == OP_SUB_W_FROM_FILE);
    endsequence

    sequence s_issue_swap;
        op_valid && (op_code == OP_SWAP_NIBBLES_FILE);
    endsequence

    sequence s_issue_xorl;
        op_valid && (op_code == OP_XOR_LITERAL_INTO_ACC);
    endsequence

    sequence s_issue_xorf;
        op_valid && (op_code == OP_XOR_ACC_WITH_FILE);
    endsequence

    // Difference lands on the result word one cycle later
    a_sub_result_word: assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
        s_issue_sub |=> done && (file_wr_data == 8'($past(file_rd_data) - $past(acc))))
        else $error("subtract result wrong");

    // Borrow-free carries from the full and low-nibble compare
    a_sub_carry_pair: assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
        s_issue_sub |=> (flag_carry == ($past(file_rd_data) >= $past(acc)))
                     && (digit_carry_flag == ($past(f_lo) >= $past(w_lo))))
        else $error("subtract carry flags wrong");

    // Destination one writes the file and leaves W alone
    a_dest_file_route: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
        op_valid && dest_bit && (op_code != OP_XOR_LITERAL_INTO_ACC)
        |=> file_we && (file_wr_addr == $past(file_addr)) && (acc == $past(acc)))
        else $error("file destination not honoured");

    // Destination zero loads W and raises no file write
    a_dest_acc_route: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
        op_valid && !dest_bit |=> !file_we && (acc == file_wr_data))
        else $error("working destination not honoured");

    // Nibbles exchanged and all three flags held
    a_swap_flags_hold: assert property (@(posedge clk_sys) disable iff (reset) // RULE_03
        s_issue_swap |=> (file_wr_data == {$past(f_lo), $past(file_rd_data[7:4])})
                      && $stable(flag_carry) && $stable(digit_carry_flag)
                      && $stable(flag_zero))
        else $error("swap changed flags or result");

    // Literal form always lands in W and keeps the carries
    a_xorl_into_acc: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
        s_issue_xorl |=> !file_we && (acc == ($past(acc) ^ $past(op_literal)))
                      && $stable(flag_carry) && $stable(digit_carry_flag))
        else $error("literal xor wrong");

    // File form: result and zero flag tied, carries untouched
    a_xorf_zero_only: assert property (@(posedge clk_sys) disable iff (reset) // RULE_05
        s_issue_xorf |=> (file_wr_data == ($past(acc) ^ $past(file_rd_data)))
                      && (flag_zero == asx_is_zero(file_wr_data))
                      && $stable(flag_carry) && $stable(digit_carry_flag))
        else $error("file xor wrong");

    // Completion pulse follows each accepted operation only
    a_done_follows: assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
        (done == ($past(op_valid) && !$past(reset))) && (!file_we || done))
        else $error("done without request");

    sequence s_no_issue;
        !op_valid;
    endsequence

    sequence s_to_acc;
        op_valid && (!dest_bit || (op_code == OP_XOR_LITERAL_INTO_ACC));
    endsequence

    sequence s_swap_to_acc;
        op_valid && (op_code == OP_SWAP_NIBBLES_FILE) && !dest_bit;
    endsequence

    // Idle cycle: no pulse; W, result word and all three flags stay put
    a_idle_holds_all: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
        s_no_issue |=> !done && !file_we && $stable(acc) && $stable(file_wr_data)
                    && $stable(flag_carry) && $stable(digit_carry_flag)
                    && $stable(flag_zero))
        else $error("idle cycle changed state");

    // W destination, or the literal form: no write, address kept
    a_acc_keeps_addr: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
        s_to_acc |=> !file_we && $stable(file_wr_addr))
        else $error("working destination wrote the file");

    // Swapped word reaches W when the destination bit is zero
    a_swap_into_acc: assert property (@(posedge clk_sys) disable iff (reset) // RULE_03
        s_swap_to_acc |=> (acc == {$past(f_lo), $past(file_rd_data[7:4])}))
        else $error("swap into working register wrong");

    // Zero flag follows the subtract difference
    a_sub_zero_flag: assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
        s_issue_sub |=> (flag_zero == (8'($past(file_rd_data) - $past(acc)) == 8'h00)))
        else $error("subtract zero flag wrong");

    // Literal form sets zero from its own result only
    a_xorl_zero_flag: assert property (@(posedge clk_sys) disable iff (reset) // RULE_04
        s_issue_xorl |=> (flag_zero == (($past(acc) ^ $past(op_literal)) == 8'h00)))
        else $error("literal xor zero flag wrong");

    // File form steered to W lands its result there
    a_xorf_into_acc: assert property (@(posedge clk_sys) disable iff (reset) // RULE_05
        op_valid && (op_code == OP_XOR_ACC_WITH_FILE) && !dest_bit
        |=> (acc == ($past(acc) ^ $past(file_rd_data))))
        else $error("file xor into working register wrong");

endmodule

// ### asx_file_model.sv
// Register file model standing on the far side of the ALU slice.
// Assumes the slice pulses file_we in the clk_sys domain.
`timescale 1ns/1ps

module asx_file_model
    import asx_pkg::*;
(
    input  wire logic      clk_sys,
    input  wire asx_addr_t file_addr,
    input  wire logic      file_we,
    input  wire asx_addr_t file_wr_addr,
    input  wire asx_data_t file_wr_data,
    output asx_data_t      file_rd_data
);
    asx_data_t mem [128];

    // Known fill, so the bench can mirror it without reading back
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37 + 11);
        end
    end

    // Combinational read, since the slice samples it with op_valid
    assign file_rd_data = mem[file_addr];

    // No forwarding: a write lands one edge after file_we rises
    always @(posedge clk_sys) begin
        if (file_we) begin
            mem[file_wr_addr] <= file_wr_data;
        end
    end
endmodule

// ### alu_sub_swap_xor_ops_test.sv
// Bench for the ALU slice: corner and random operations checked
// against a bench model. Assumes asx_file_model on the file port.
`timescale 1ns/1ps

module alu_sub_swap_xor_ops_test;
    import asx_pkg::*;

    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        op_valid = 1'b0;
    asx_op_e     op_code = OP_SUB_W_FROM_FILE;
    logic        dest_bit = 1'b0;
    asx_addr_t   file_addr = 7'h00;
    asx_data_t   op_literal = 8'h00;
    asx_data_t   file_rd_data, acc, file_wr_data, m_w;
    asx_addr_t   file_wr_addr;
    logic        done, file_we, flag_carry, digit_carry_flag, flag_zero;
    logic        m_c, m_digit, m_z;
    asx_data_t   exp_mem [128];
    logic [31:0] seed = 32'd49730;
    logic [31:0] v;
    int          error_cnt = 0;
    int          checks_done = 0;

    always #50 clk_sys = ~clk_sys;

    asx_alu_top u_dut (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid),
        .op_code(op_code), .dest_bit(dest_bit), .file_addr(file_addr),
        .file_rd_data(file_rd_data), .op_literal(op_literal), .done(done), .acc(acc),
        .file_we(file_we), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
        .flag_carry(flag_carry), .digit_carry_flag(digit_carry_flag),
        .flag_zero(flag_zero));

    asx_file_model u_file (.clk_sys(clk_sys), .file_addr(file_addr), .file_we(file_we),
        .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
        .file_rd_data(file_rd_data));

    // Xorshift source, fixed start so a failure replays
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        checks_done++;
        if (seen !== expv) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Entered at a rising edge; b2b keeps op_valid up for the next call
    task automatic run_op(input asx_op_e op, input logic d, input asx_addr_t a,
                          input asx_data_t k, input bit b2b);
        asx_data_t f, r, ew;
        logic      wf, ec, edc, ez;
        f = exp_mem[a];
        ec = m_c;
        edc = m_digit;
        ez = m_z;
        case (op)
            OP_SUB_W_FROM_FILE: begin
                r = f - m_w;
                ec = (f >= m_w);
                edc = (f[3:0] >= m_w[3:0]);
            end
            OP_SWAP_NIBBLES_FILE: r = {f[3:0], f[7:4]};
            OP_XOR_LITERAL_INTO_ACC: r = m_w ^ k;
            default: r = m_w ^ f;
        endcase
        if (op != OP_SWAP_NIBBLES_FILE) ez = (r == 8'h00);
        wf = d && (op != OP_XOR_LITERAL_INTO_ACC);
        if (wf) exp_mem[a] = r;
        else m_w = r;
        ew = m_w;
        {m_c, m_digit, m_z} = {ec, edc, ez};
        op_valid <= 1'b1;
        op_code <= op;
        dest_bit <= d;
        file_addr <= a;
        op_literal <= k;
        @(posedge clk_sys);
        if (!b2b) op_valid <= 1'b0;
        fork
            begin
                @(negedge clk_sys);
                check(done, 8'h01);
                check(file_we, wf);
                check(file_wr_data, r);
                if (wf) check(8'(file_wr_addr), 8'(a));
                check(acc, ew);
                check(flag_carry, ec);
                check(digit_carry_flag, edc);
                check(flag_zero, ez);
                if (!b2b) begin
                    @(negedge clk_sys);
                    check({done, file_we}, 8'h00);
                end
            end
        join_none
    endtask

    task automatic do_reset(input int n);
        reset <= 1'b1;
        op_valid <= 1'b0;
        repeat (n - 1) @(posedge clk_sys);
        @(negedge clk_sys);
        check({flag_carry, digit_carry_flag, flag_zero, done, file_we}, 8'h00);
        check(acc | file_wr_data | 8'(file_wr_addr), 8'h00);
        @(posedge clk_sys);
        reset <= 1'b0;
        {m_w, m_c, m_digit, m_z} = '0;
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #(100 * 3000);
        error_cnt++;
        conclude();
    end

    initial begin
        for (int i = 0; i < 128; i++) exp_mem[i] = 8'(i * 37 + 11);
        do_reset(8);
        @(posedge clk_sys);
        run_op(OP_XOR_LITERAL_INTO_ACC, 1'b1, 7'h00, 8'h01, 1'b0);
        @(posedge clk_sys);
        run_op(OP_SUB_W_FROM_FILE, 1'b1, 7'h05, 8'h00, 1'b0);
        @(posedge clk_sys);
        run_op(OP_XOR_LITERAL_INTO_ACC, 1'b0, 7'h00, m_w, 1'b0);
        @(posedge clk_sys);
        run_op(OP_XOR_LITERAL_INTO_ACC, 1'b0, 7'h00, 8'hff, 1'b0);
        @(posedge clk_sys);
        run_op(OP_SUB_W_FROM_FILE, 1'b0, 7'h03, 8'h00, 1'b0);
        @(posedge clk_sys);
        run_op(OP_XOR_LITERAL_INTO_ACC, 1'b0, 7'h00, m_w ^ exp_mem[9], 1'b0);
        @(posedge clk_sys);
        run_op(OP_SUB_W_FROM_FILE, 1'b1, 7'h09, 8'h00, 1'b1);
        run_op(OP_SWAP_NIBBLES_FILE, 1'b0, 7'h0a, 8'h00, 1'b1);
        run_op(OP_SWAP_NIBBLES_FILE, 1'b1, 7'h0b, 8'h00, 1'b1);
        run_op(OP_XOR_ACC_WITH_FILE, 1'b1, 7'h0c, 8'h00, 1'b1);
        run_op(OP_XOR_ACC_WITH_FILE, 1'b0, 7'h7f, 8'h00, 1'b0);
        @(posedge clk_sys);
        $display("corner test done");
        do_reset(2);
        $display("reset test done");
        for (int n = 0; n < 200; n++) begin
            v = rnd();
            @(posedge clk_sys);
            run_op(asx_op_e'(v[1:0]), v[2], v[9:3], v[17:10], 1'b0);
        end
        repeat (3) @(posedge clk_sys);
        $display("random test done");
        conclude();
    end
endmodule
